/* verilog/emasr_regs.v */
/*
  Energy meter, alert mask and snapshot control register bank.
  Holds the two alert enable masks, the 48-bit energy accumulator, the
  32-bit conversion cycle counter, meter control and status, and the
  snapshot input select and mode.
  Assumes a serial management bus front end that presents byte reads and
  writes on a simple address/strobe port, one access per strobe, and an
  ADC core that pulses conversion completion with the power result for
  that cycle. All inputs are synchronous to sys_clk.
*/
// Functional notes
// - Mask byte at 0x19 enables drain, divided drain and sense alerts, reset zero.
// - Mask byte at 0x1A enables differential pair alerts, reset zero.
// - Energy is a 48-bit host read/write accumulator resetting to zero.
// - Energy occupies six byte addresses 0x7A to 0x7F, all read/write.
// - A 32-bit counter, reset zero, counts accumulated conversion cycles.
// - The cycle counter occupies bytes 0x80 to 0x83, all read/write.
// - Meter reset bit holds accumulator and counter at zero until cleared.
// - Meter halt bit freezes accumulator and counter at present values.
// - Counter wrap sets the cycle overflow bit.
// - Accumulator wrap sets the energy overflow bit.
// - Alert latches a sticky bit that only a host write clears.
// - Bit 2 reports nonvolatile memory factory lock, read-only.
// - Meter control bits 1:0 ignore writes and read zero.
// - Snapshot bits 7:4 select one of sixteen inputs, reset zero.
// - Snapshot bit 3 picks snapshot mode, zero keeps continuous conversion.
`timescale 1ns/1ps
`include "emasr_defs.vh"

module emasr_regs #(
  parameter POWER_W = 24
) (
  input  wire                sys_clk,
  input  wire                reset_n,
  input  wire [7:0]          reg_addr,
  input  wire                reg_wr,
  input  wire [7:0]          reg_wdata,
  input  wire                reg_rd,
  output reg  [7:0]          reg_rdata,
  input  wire                conv_done,
  input  wire [POWER_W-1:0]  power_result,
  input  wire                alert_raised,
  input  wire                nvm_factory_locked,
  output wire [7:0]          drain_sense_alert_mask,
  output wire [7:0]          differential_alert_mask,
  output wire [3:0]          snapshot_select,
  output wire                snapshot_mode
);

  // Multi-byte values are read one byte per access with no shadow copy, so a
  // host that wants a coherent energy or count reading sets the halt bit first.
  // Accumulation beats a same-cycle host write to the value bytes, and a
  // hardware flag set beats a host clear, so no event is ever lost; the price
  // is that such a host write can be dropped, which the host sees on read-back.
  // While the meter reset bit is set, host writes to the values are dropped.

  // Alert enable masks and snapshot control, written only by the host.
  reg  [7:0]  drain_mask_reg;
  reg  [7:0]  diff_mask_reg;
  reg  [7:0]  snap_reg;
  // Meter values and their next-state terms.
  reg  [47:0] energy_reg;
  reg  [47:0] energy_next;
  reg  [31:0] cycle_reg;
  reg  [31:0] cycle_next;
  // Meter control bits; the status flags have next-state terms.
  reg         meter_reset_reg;
  reg         meter_halt_reg;
  reg         cycle_ovf_reg;
  reg         cycle_ovf_next;
  reg         energy_ovf_reg;
  reg         energy_ovf_next;
  reg         alert_seen_reg;
  reg         alert_seen_next;
  // Sums one bit wider than the values so the carry out shows a wrap.
  reg  [48:0] energy_sum;
  reg  [32:0] cycle_sum;
  // Byte lanes of the multi-byte values picked by the low address bits.
  wire [2:0]  eidx;
  wire [1:0]  cidx;
  // Read data before the output flip-flop.
  reg  [7:0]  rdata_next;
  // Decoded host write strobes, one per register.
  wire        wr_drain_mask;
  wire        wr_diff_mask;
  wire        wr_energy;
  wire        wr_cycle;
  wire        wr_meter;
  wire        wr_snap;
  // Address falls in one of the multi-byte windows.
  wire        in_energy;
  wire        in_cycle;
  wire        accumulate;
  wire [7:0]  meter_byte;

  // Address windows of the multi-byte values.
  assign in_energy = (reg_addr >= `EMASR_ADDR_ENERGY_LO) &&
                     (reg_addr <= `EMASR_ADDR_ENERGY_HI);
  assign in_cycle  = (reg_addr >= `EMASR_ADDR_CYCLE_LO) &&
                     (reg_addr <= `EMASR_ADDR_CYCLE_HI);

  // Byte lane in each window; the energy window starts two above a multiple of eight.
  assign eidx = reg_addr[2:0] - 3'h2;
  assign cidx = reg_addr[1:0];

  // One write strobe per register; other addresses are ignored.
  assign wr_drain_mask = reg_wr && (reg_addr == `EMASR_ADDR_DRAIN_MASK);
  assign wr_diff_mask  = reg_wr && (reg_addr == `EMASR_ADDR_DIFF_MASK);
  assign wr_energy     = reg_wr && in_energy;
  assign wr_cycle      = reg_wr && in_cycle;
  assign wr_meter      = reg_wr && (reg_addr == `EMASR_ADDR_METER_CTRL);
  assign wr_snap       = reg_wr && (reg_addr == `EMASR_ADDR_SNAPSHOT);

  // A conversion counts only while the meter is neither reset nor halted.
  assign accumulate = conv_done && !meter_reset_reg && !meter_halt_reg;

  // Meter control as the host reads it; the lock bit is shown live.
  assign meter_byte = {meter_reset_reg, meter_halt_reg, cycle_ovf_reg, energy_ovf_reg,
                       alert_seen_reg, nvm_factory_locked, 2'b00};

  // Register outputs toward the alert and ADC logic.
  assign drain_sense_alert_mask  = drain_mask_reg;
  assign differential_alert_mask = diff_mask_reg;
  assign snapshot_select         = snap_reg[7:4];
  assign snapshot_mode           = snap_reg[`EMASR_BIT_SNAP_MODE];

  // Wide sums; the top bit is the carry out that flags a wrap.
  always @*
  begin
    energy_sum = {1'b0, energy_reg} + {{(49-POWER_W){1'b0}}, power_result};
    cycle_sum  = {1'b0, cycle_reg} + 33'h000000001;
  end

  // Next energy value; host byte writes land first, then accumulation.
  always @*
  begin
    energy_next = energy_reg;
    if (wr_energy)
    begin
      energy_next[eidx*8 +: 8] = reg_wdata;
    end
    // Accumulation wins over a same-cycle host write so no conversion is lost.
    if (accumulate)
    begin
      energy_next = energy_sum[47:0];
    end
    // Meter reset holds the value at zero and drops host writes meanwhile.
    if (meter_reset_reg)
    begin
      energy_next = `EMASR_ENERGY_RESET;
    end
  end

  // Next cycle counter value, built in the same order as the energy value.
  always @*
  begin
    cycle_next = cycle_reg;
    if (wr_cycle)
    begin
      cycle_next[cidx*8 +: 8] = reg_wdata;
    end
    // The counter steps with the accumulator so the two always agree.
    if (accumulate)
    begin
      cycle_next = cycle_sum[31:0];
    end
    // Meter reset holds the count at zero.
    if (meter_reset_reg)
    begin
      cycle_next = `EMASR_CYCLE_RESET;
    end
  end

  // Next status flags; a hardware set beats a host clear in the same cycle.
  always @*
  begin
    energy_ovf_next = energy_ovf_reg;
    cycle_ovf_next  = cycle_ovf_reg;
    alert_seen_next = alert_seen_reg;
    // A host write stores the written value, so writing zero clears a flag.
    if (wr_meter)
    begin
      energy_ovf_next = reg_wdata[`EMASR_BIT_ENERGY_OVF];
      cycle_ovf_next  = reg_wdata[`EMASR_BIT_CYCLE_OVF];
      alert_seen_next = reg_wdata[`EMASR_BIT_ALERT_SEEN];
    end
    if (accumulate && energy_sum[48])
    begin
      energy_ovf_next = 1'b1;
    end
    if (accumulate && cycle_sum[32])
    begin
      cycle_ovf_next = 1'b1;
    end
    if (alert_raised)
    begin
      alert_seen_next = 1'b1;
    end
  end

  // Alert masks; written only by the host.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drain_mask_reg <= `EMASR_MASK_RESET;
      diff_mask_reg  <= `EMASR_MASK_RESET;
    end
    else
    begin
      if (wr_drain_mask)
        drain_mask_reg <= reg_wdata;
      if (wr_diff_mask)
        diff_mask_reg <= reg_wdata;
    end
  end

  // Snapshot control; the spare low bits are never stored.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      snap_reg <= `EMASR_SNAP_RESET;
    else if (wr_snap)
      snap_reg <= {reg_wdata[7:3], 3'b000};
  end

  // Meter reset and halt bits; written directly by the host.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meter_reset_reg <= 1'b0;
      meter_halt_reg  <= 1'b0;
    end
    else if (wr_meter)
    begin
      meter_reset_reg <= reg_wdata[`EMASR_BIT_METER_RESET];
      meter_halt_reg  <= reg_wdata[`EMASR_BIT_METER_HALT];
    end
  end

  // Meter values and status flags.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      energy_reg     <= `EMASR_ENERGY_RESET;
      cycle_reg      <= `EMASR_CYCLE_RESET;
      energy_ovf_reg <= 1'b0;
      cycle_ovf_reg  <= 1'b0;
      alert_seen_reg <= 1'b0;
    end
    else
    begin
      energy_reg     <= energy_next;
      cycle_reg      <= cycle_next;
      energy_ovf_reg <= energy_ovf_next;
      cycle_ovf_reg  <= cycle_ovf_next;
      alert_seen_reg <= alert_seen_next;
    end
  end

  // Read data mux; unmapped addresses give zero.
  always @*
  begin
    rdata_next = 8'h00;
    case (reg_addr)
      // Alert enable masks.
      `EMASR_ADDR_DRAIN_MASK:
      begin
        rdata_next = drain_mask_reg;
      end
      `EMASR_ADDR_DIFF_MASK:
      begin
        rdata_next = diff_mask_reg;
      end
      // Energy bytes, least significant byte at the lowest address.
      `EMASR_ADDR_ENERGY_LO:
      begin
        rdata_next = energy_reg[7:0];
      end
      (`EMASR_ADDR_ENERGY_LO + 8'h01):
      begin
        rdata_next = energy_reg[15:8];
      end
      (`EMASR_ADDR_ENERGY_LO + 8'h02):
      begin
        rdata_next = energy_reg[23:16];
      end
      (`EMASR_ADDR_ENERGY_LO + 8'h03):
      begin
        rdata_next = energy_reg[31:24];
      end
      (`EMASR_ADDR_ENERGY_LO + 8'h04):
      begin
        rdata_next = energy_reg[39:32];
      end
      `EMASR_ADDR_ENERGY_HI:
      begin
        rdata_next = energy_reg[47:40];
      end
      // Cycle counter bytes, least significant byte at the lowest address.
      `EMASR_ADDR_CYCLE_LO:
      begin
        rdata_next = cycle_reg[7:0];
      end
      (`EMASR_ADDR_CYCLE_LO + 8'h01):
      begin
        rdata_next = cycle_reg[15:8];
      end
      (`EMASR_ADDR_CYCLE_LO + 8'h02):
      begin
        rdata_next = cycle_reg[23:16];
      end
      `EMASR_ADDR_CYCLE_HI:
      begin
        rdata_next = cycle_reg[31:24];
      end
      // Control and status bytes.
      `EMASR_ADDR_METER_CTRL:
      begin
        rdata_next = meter_byte;
      end
      `EMASR_ADDR_SNAPSHOT:
      begin
        rdata_next = snap_reg;
      end
      default:
      begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // Read data is registered and stands until the next read.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_next;
  end

endmodule // emasr_regs

/* verilog/emasr_defs.vh */
/*
  Register offsets, field positions and reset values for the energy meter,
  alert mask and snapshot register bank. Assumes byte-wide register access.
*/
`ifndef EMASR_DEFS_VH
`define EMASR_DEFS_VH
`define EMASR_ADDR_DRAIN_MASK   8'h19
`define EMASR_ADDR_DIFF_MASK    8'h1A
`define EMASR_ADDR_ENERGY_LO    8'h7A
`define EMASR_ADDR_ENERGY_HI    8'h7F
`define EMASR_ADDR_CYCLE_LO     8'h80
`define EMASR_ADDR_CYCLE_HI     8'h83
`define EMASR_ADDR_METER_CTRL   8'h84
`define EMASR_ADDR_SNAPSHOT     8'h85
`define EMASR_BIT_METER_RESET   7
`define EMASR_BIT_METER_HALT    6
`define EMASR_BIT_CYCLE_OVF     5
`define EMASR_BIT_ENERGY_OVF    4
`define EMASR_BIT_ALERT_SEEN    3
`define EMASR_BIT_NVM_LOCKED    2
`define EMASR_BIT_SNAP_MODE     3
`define EMASR_MASK_RESET        8'h00
`define EMASR_ENERGY_RESET      48'h000000000000
`define EMASR_CYCLE_RESET       32'h00000000
`define EMASR_SNAP_RESET        8'h00
`endif

/* test/emasr_props.sv */
/* Checker on the register bank ports.
   Assumes one clock and a bind by name from the bench. */
`timescale 1ns/1ps
module emasr_props (
  input wire       sys_clk,
  input wire       reset_n,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire [7:0] reg_wdata,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       alert_raised,
  input wire       nvm_factory_locked,
  input wire [7:0] drain_sense_alert_mask,
  input wire [7:0] differential_alert_mask,
  input wire [3:0] snapshot_select,
  input wire       snapshot_mode
);
  // Decoded host strobes.
  wire wr85 = reg_wr && reg_addr == 8'h85;
  wire rd84 = reg_rd && reg_addr == 8'h84;
  wire rd85 = reg_rd && reg_addr == 8'h85;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_m1; reg_wr && reg_addr == 8'h19 |=> drain_sense_alert_mask == $past(reg_wdata);
  endproperty
  a_m1: assert property (p_m1) else $error("drain mask write lost");
  property p_m2; reg_wr && reg_addr == 8'h1A |=> differential_alert_mask == $past(reg_wdata);
  endproperty
  a_m2: assert property (p_m2) else $error("pair mask write lost");
  property p_sel; wr85 |=> {snapshot_select, snapshot_mode} == $past(reg_wdata[7:3]); endproperty
  a_sel: assert property (p_sel) else $error("snapshot write lost");
  property p_lck; rd84 |=> reg_rdata[2] == $past(nvm_factory_locked); endproperty
  a_lck: assert property (p_lck) else $error("lock bit wrong");
  property p_rsv; rd84 |=> reg_rdata[1:0] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("meter spare bits set");
  property p_srv; rd85 |=> reg_rdata[2:0] == 3'h0; endproperty
  a_srv: assert property (p_srv) else $error("snapshot spare bits set");
  property p_alr; alert_raised ##1 rd84 |=> reg_rdata[3]; endproperty
  a_alr: assert property (p_alr) else $error("alert not latched");
  property p_clr; (reg_wr && reg_addr == 8'h84 && reg_wdata[7]) ##1 !reg_wr
    ##1 (reg_rd && reg_addr == 8'h7A) |=> reg_rdata == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("meter reset ignored");
endmodule // emasr_props

/* test/emasr_host.sv */
/* Host model issuing byte reads and writes.
   Assumes the bench calls its tasks at a falling edge. */
`timescale 1ns/1ps
module emasr_host (
  input  wire       sys_clk,
  input  wire [7:0] reg_rdata,
  output reg  [7:0] reg_addr,
  output reg        reg_wr,
  output reg  [7:0] reg_wdata,
  output reg        reg_rd
);
  // Idle bus at time zero.
  initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h0;
  // One write strobe; data is scrambled once it is no longer qualified.
  task wr(input [7:0] a, input [7:0] v);
    @(negedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
    @(negedge sys_clk);
    {reg_wdata, reg_wr} = {~v, 1'b0};
  endtask
  // One read strobe; data is taken after the taking edge.
  task rd(input [7:0] a, output [7:0] v);
    @(negedge sys_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge sys_clk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask
endmodule // emasr_host

/* test/emasr_regs_bench.sv */
/* Bench for the register bank.
   Assumes the host model and checker files are compiled first. */
`timescale 1ns/1ps
module emasr_regs_bench;
  reg         sys_clk = 1'b0, reset_n = 1'b0, conv_done = 1'b0, alert_raised = 1'b0;
  reg         nvm_factory_locked = 1'b0;
  reg  [23:0] power_result = 24'h0;
  wire [7:0]  reg_addr, reg_wdata, reg_rdata, drain_sense_alert_mask, differential_alert_mask;
  wire [3:0]  snapshot_select;
  wire        reg_wr, reg_rd, snapshot_mode;
  integer     errors = 0, n_tests = 0, i;
  reg  [7:0]  d;
  emasr_regs u_emasr_regs (.*);
  emasr_host u_emasr_host (.*);
  // Clock of 4 ns.
  always #2 sys_clk = ~sys_clk;
  task end_sim;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task cmp(input [7:0] g, input [7:0] e);
    n_tests = n_tests + 1;
    errors = errors + (g !== e);
    if (g !== e) $display("ERROR %0t got %h exp %h", $time, g, e);
  endtask
  task chk(input [7:0] a, input [7:0] e);
    u_emasr_host.rd(a, d);
    cmp(d, e);
  endtask
  task pulse(input [23:0] p);
    {conv_done, power_result} = {1'b1, p};
    @(negedge sys_clk);
    conv_done = 1'b0;
  endtask
  task t_reset;
    for (i = 8'h7A; i < 8'h86; i = i + 1) chk(i[7:0], 8'h00);
    chk(8'h19, 8'h00);
    chk(8'h1A, 8'h00);
  endtask
  task t_masks;
    u_emasr_host.wr(8'h19, 8'hA5);
    u_emasr_host.wr(8'h1A, 8'h5A);
    cmp(drain_sense_alert_mask, 8'hA5);
    cmp(differential_alert_mask, 8'h5A);
    chk(8'h1A, 8'h5A);
  endtask
  task t_wrap;
    for (i = 8'h7A; i < 8'h84; i = i + 1) u_emasr_host.wr(i[7:0], 8'hFF);
    pulse(24'h000001);
    for (i = 8'h7A; i < 8'h84; i = i + 1) chk(i[7:0], 8'h00);
    chk(8'h84, 8'h30);
  endtask
  task t_meter;
    u_emasr_host.wr(8'h84, 8'h00);
    pulse(24'h00ABCD);
    chk(8'h7B, 8'hAB);
    chk(8'h80, 8'h01);
    u_emasr_host.wr(8'h84, 8'h40);
    pulse(24'h000001);
    chk(8'h7A, 8'hCD);
    chk(8'h80, 8'h01);
    u_emasr_host.wr(8'h84, 8'h80);
    chk(8'h7A, 8'h00);
    u_emasr_host.wr(8'h84, 8'h00);
    chk(8'h80, 8'h00);
  endtask
  task t_ctrl;
    {nvm_factory_locked, alert_raised} = 2'b11;
    chk(8'h84, 8'h0C);
    alert_raised = 1'b0;
    u_emasr_host.wr(8'h84, 8'h03);
    chk(8'h84, 8'h04);
  endtask
  task t_snap;
    for (i = 0; i < 16; i = i + 1)
    begin
      u_emasr_host.wr(8'h85, {i[3:0], 4'hF});
      cmp({snapshot_select, snapshot_mode, 3'h0}, {i[3:0], 4'h8});
      chk(8'h85, {i[3:0], 4'h8});
    end
  endtask
  // Reset, then the scenarios in turn.
  initial
  begin
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    t_reset;
    t_masks;
    t_wrap;
    t_meter;
    t_ctrl;
    t_snap;
    end_sim;
  end
  // Watchdog well beyond the expected run.
  initial
  begin
    #40000;
    errors = errors + 1;
    end_sim;
  end
endmodule // emasr_regs_bench
bind emasr_regs emasr_props u_emasr_props (.*);
